//--- npec_ctrl.sv
// npec_ctrl: flash program/erase sequencer with its control register, event
// status, regulator standby control and power-save gating.
// Assumes idle and power-save inputs come from core logic and abort from the flash array, all on MCLK_I.
// Assumes the flash array takes strobe levels and times nothing itself.
//
// How it works
// - setting the start bit launches the selected cycle, timed here, and hardware clears it at the end.
// - the error flag is set on a bad start or an early end, and cleared on a normal completion.
// - with standby-in-idle set the regulator goes to standby during idle, otherwise it stays active.
// - after leaving idle from standby a wake delay passes before a flash cycle proceeds.
// - the select field picks word program or erase, and every other code starts nothing.
// - a power-save instruction is ignored and no low-power state entered while a cycle runs.
// - control bits 11 to 4 read as zero.
`timescale 1ns/1ps
module npec_ctrl
  import npec_pkg::*;
#(
  parameter int PROG_CYCLES  = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int WAKE_CYCLES  = WAKE_CYC
) (
  // clock and reset
  input  wire logic                MCLK_I,
  input  wire logic                RST_B_I,
  // register port
  input  wire logic [REG_AW-1:0]   REG_ADDR_I,
  input  wire logic [CTRL_W-1:0]   REG_WDATA_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  output logic      [CTRL_W-1:0]   REG_RDATA_O,
  // core power management
  input  wire logic                CPU_IDLE_I,
  input  wire logic                POWER_SAVE_INSTR_I,
  output logic                     LOW_POWER_ENTER_O,
  output logic                     REGULATOR_STANDBY_O,
  output logic                     FLASH_READY_O,
  // flash array
  input  wire logic                FLASH_ABORT_I,
  output logic                     FLASH_PROGRAM_O,
  output logic                     FLASH_ERASE_O,
  output logic                     FLASH_BUSY_O,
  // interrupt
  output logic                     IRQ_O
);

  // operation_select decode, used only at start qualification
  // reserved codes, 0010 among them, fall through as invalid
  function automatic logic op_is_valid(input logic [3:0] op);
    return (op == OP_WORD_PROG) || (op == OP_ERASE);
  endfunction

  // timed length of an operation in cycles
  // word program is the fallback; only erase takes the long count
  function automatic logic [TMR_W-1:0] op_cycles(input logic [3:0] op);
    if (op == OP_ERASE) begin
      return TMR_W'(ERASE_CYCLES);
    end else begin
      return TMR_W'(PROG_CYCLES);
    end
  endfunction

  // control register fields
  // bits 11 to 4 have no storage at all
  logic              start_q;
  logic              program_erase_enable_q;
  logic              err_q;
  logic              sidl_q;
  logic [3:0]        op_q;

  // event status, mask, read data
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  logic [STAT_W-1:0] mask_q;
  logic [STAT_W-1:0] ev;
  logic [CTRL_W-1:0] rdata_q;

  // sequencer
  npec_state_t       state_q;
  npec_state_t       state_d;
  logic              prog_q;
  logic              erase_q;

  // regulator and power save
  // wake counter is sized for the default delay
  logic              standby_q;
  logic              idle_q;
  logic              waking_q;
  logic [WAKE_W-1:0] wake_cnt_q;
  logic              lp_enter_q;

  // decoded strobes and sequence events
  // combinational terms, none of them registered
  logic              wr_ctrl;
  logic              wr_mask;
  logic              rd_stat;
  logic              start_req;
  logic              start_ok;
  logic              start_bad;
  logic              busy;
  logic              launch;
  logic              finish;
  logic              abort;
  logic              psi_ignored;

  // timer link; the count is sampled only on the load pulse
  npec_tmr_if #(.W(TMR_W)) tif ();

  npec_timer #(
    .W       (TMR_W)
  ) u_timer (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .tif     (tif)
  );

  // register port decode
  // unmapped index matches nothing, so writes there are dropped
  assign wr_ctrl = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);
  assign wr_mask = REG_WR_I && (REG_ADDR_I == ADDR_MASK);
  assign rd_stat = REG_RD_I && (REG_ADDR_I == ADDR_STAT);

  // start qualification; write-enable must already be set, so a single write
  // carrying both bits counts as an improper sequence
  // a start while busy is dropped quietly, it neither errs nor restarts
  assign busy      = (state_q != NPEC_IDLE);
  assign start_req = wr_ctrl && REG_WDATA_I[CTRL_START_BIT] && !busy;
  assign start_ok  = start_req && program_erase_enable_q && op_is_valid(op_q);
  assign start_bad = start_req && !start_ok;

  // launch only once the regulator is awake again and the timer is free;
  // an abort in the same cycle wins over both launch and expiry
  assign launch = (state_q == NPEC_PEND) && !waking_q && !tif.busy && !FLASH_ABORT_I;
  assign finish = (state_q == NPEC_RUN) && tif.expire && !FLASH_ABORT_I;
  assign abort  = FLASH_ABORT_I && ((state_q == NPEC_PEND) || (state_q == NPEC_RUN));

  // power save request seen while a cycle is pending or running
  // the instruction is swallowed, only the status bit records it
  assign psi_ignored = POWER_SAVE_INSTR_I && busy;

  // timer control
  // stop beats load inside the timer, so an abort never relaunches
  assign tif.load  = launch;
  assign tif.stop  = abort;
  assign tif.count = op_cycles(op_q);

  // sequencer next state
  // the finish state leaves one cycle for the start bit to clear
  always_comb begin
    state_d = state_q;
    case (state_q)
      NPEC_IDLE: begin
        if (start_ok) begin
          state_d = NPEC_PEND;
        end
      end
      NPEC_PEND: begin
        if (abort) begin
          state_d = NPEC_IDLE;
        end else if (launch) begin
          state_d = NPEC_RUN;
        end
      end
      NPEC_RUN: begin
        if (abort) begin
          state_d = NPEC_IDLE;
        end else if (finish) begin
          state_d = NPEC_FINISH;
        end
      end
      NPEC_FINISH: begin
        state_d = NPEC_IDLE;
      end
      default: begin
        state_d = NPEC_IDLE;
      end
    endcase
  end

  // sequencer state register
  // one-hot codes; a corrupt code falls back to idle via the default
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      state_q <= NPEC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // flash strobes, held for the whole timed cycle only
  // they drop on the same edge that posts the done status
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      prog_q  <= 1'b0;
      erase_q <= 1'b0;
    end else if (abort || finish) begin
      prog_q  <= 1'b0;
      erase_q <= 1'b0;
    end else if (launch) begin
      prog_q  <= (op_q == OP_WORD_PROG);
      erase_q <= (op_q == OP_ERASE);
    end
  end

  // start bit: set-only from software, cleared by hardware at the end
  // a software write of zero has no effect on it
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      start_q <= CTRL_RESET[CTRL_START_BIT];
    end else if (start_ok) begin
      start_q <= 1'b1;
    end else if ((state_q == NPEC_FINISH) || abort) begin
      start_q <= 1'b0;
    end
  end

  // sequence error flag; hardware set beats a software clear
  // a normal finish clears it, never in a cycle that also sets it
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      err_q <= CTRL_RESET[CTRL_ERR_BIT];
    end else if (start_bad || abort) begin
      err_q <= 1'b1;
    end else if (finish) begin
      err_q <= 1'b0;
    end else if (wr_ctrl) begin
      err_q <= REG_WDATA_I[CTRL_ERR_BIT];
    end
  end

  // write-enable and operation select, frozen while a cycle is in flight
  // so the running operation cannot be retargeted halfway
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      program_erase_enable_q <= CTRL_RESET[CTRL_PROGRAM_ERASE_ENABLE_BIT];
      op_q   <= OP_RESET;
    end else if (wr_ctrl && !busy) begin
      program_erase_enable_q <= REG_WDATA_I[CTRL_PROGRAM_ERASE_ENABLE_BIT];
      op_q   <= REG_WDATA_I[OP_MSB:OP_LSB];
    end
  end

  // standby-in-idle control, writable at any time
  // a change during idle shows on the regulator one cycle later
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      sidl_q <= CTRL_RESET[CTRL_SIDL_BIT];
    end else if (wr_ctrl) begin
      sidl_q <= REG_WDATA_I[CTRL_SIDL_BIT];
    end
  end

  // regulator standby follows idle only when standby-in-idle is set
  // idle comes from core logic on this clock, so no synchroniser
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      standby_q <= 1'b0;
      idle_q    <= 1'b0;
    end else begin
      standby_q <= CPU_IDLE_I && sidl_q;
      idle_q    <= CPU_IDLE_I;
    end
  end

  // wake delay after idle ends with the regulator in standby
  // a fresh idle exit during the delay restarts the count
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      wake_cnt_q <= '0;
      waking_q   <= 1'b0;
    end else if (idle_q && !CPU_IDLE_I && standby_q) begin
      wake_cnt_q <= WAKE_W'(WAKE_CYCLES - 1);
      waking_q   <= 1'b1;
    end else if (wake_cnt_q != '0) begin
      wake_cnt_q <= wake_cnt_q - WAKE_W'(1);
    end else begin
      waking_q   <= 1'b0;
    end
  end

  // low-power entry pulse, refused while the sequencer is busy
  // a pulse, not a level; the core keeps its own sleep state
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      lp_enter_q <= 1'b0;
    end else begin
      lp_enter_q <= POWER_SAVE_INSTR_I && !busy;
    end
  end

  // events into sticky status; a read clears, a new event wins
  // done and error never meet: an abort blocks the finish
  always_comb begin
    ev                = '0;
    ev[STAT_DONE_BIT] = finish;
    ev[STAT_ERR_BIT]  = start_bad || abort;
    ev[STAT_PSI_BIT]  = psi_ignored;
    stat_d            = rd_stat ? ev : (stat_q | ev);
  end

  // status and mask registers
  // a mask write counts from the next cycle's interrupt level
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      stat_q <= STAT_RESET;
      mask_q <= MASK_RESET;
    end else begin
      stat_q <= stat_d;
      if (wr_mask) begin
        mask_q <= REG_WDATA_I[STAT_W-1:0];
      end
    end
  end

  // read data, valid the cycle after the strobe; unmapped reads give zero
  // zero between reads keeps a shared read bus quiet
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      rdata_q <= '0;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_CTRL: rdata_q <= {start_q, program_erase_enable_q, err_q, sidl_q, 8'h00, op_q};
        ADDR_STAT: rdata_q <= {{(CTRL_W-STAT_W){1'b0}}, stat_q};
        ADDR_MASK: rdata_q <= {{(CTRL_W-STAT_W){1'b0}}, mask_q};
        default:   rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // outputs
  // busy mirrors the start bit, which also covers the wake wait
  assign REG_RDATA_O         = rdata_q;
  assign LOW_POWER_ENTER_O   = lp_enter_q;
  assign REGULATOR_STANDBY_O = standby_q;
  assign FLASH_READY_O       = !waking_q;
  assign FLASH_PROGRAM_O     = prog_q;
  assign FLASH_ERASE_O       = erase_q;
  assign FLASH_BUSY_O        = start_q;
  // level interrupt, no edge: stays up until software reads status
  assign IRQ_O               = |(stat_q & mask_q);

endmodule : npec_ctrl

//--- npec_ctrl_asserts.sv
// npec_ctrl_asserts: port checks on the flash sequencer.
// Assumes binding into npec_ctrl with its timing parameters.
`timescale 1ns/1ps
module npec_ctrl_asserts
  import npec_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  // clock and reset
  input wire logic              MCLK_I,
  input wire logic              RST_B_I,
  // register port
  input wire logic [REG_AW-1:0] REG_ADDR_I,
  input wire logic [CTRL_W-1:0] REG_WDATA_I,
  input wire logic              REG_WR_I,
  input wire logic              REG_RD_I,
  input wire logic [CTRL_W-1:0] REG_RDATA_O,
  // power and flash
  input wire logic              CPU_IDLE_I,
  input wire logic              POWER_SAVE_INSTR_I,
  input wire logic              LOW_POWER_ENTER_O,
  input wire logic              REGULATOR_STANDBY_O,
  input wire logic              FLASH_READY_O,
  input wire logic              FLASH_ABORT_I,
  input wire logic              FLASH_PROGRAM_O,
  input wire logic              FLASH_ERASE_O,
  input wire logic              FLASH_BUSY_O
);
  localparam int PM1 = PROG_CYCLES - 1;
  localparam int WM1 = WAKE_CYCLES - 1;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  logic wen_q;
  logic cwr;
  logic stb;
  // helper terms; busy writes to write-enable and select are dropped by the block
  assign cwr = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);
  assign stb = FLASH_PROGRAM_O || FLASH_ERASE_O;
  // write-enable as stored before the current write
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      wen_q <= 1'b0;
    end else if (cwr && !FLASH_BUSY_O) begin
      wen_q <= REG_WDATA_I[CTRL_PROGRAM_ERASE_ENABLE_BIT];
    end
  end
  a_start_launch: assert property ($rose(FLASH_BUSY_O) && FLASH_READY_O && !REGULATOR_STANDBY_O
    && !FLASH_ABORT_I |=> FLASH_PROGRAM_O ^ FLASH_ERASE_O) else $error("no strobe after start");
  a_prog_length: assert property (@(posedge MCLK_I) disable iff (!RST_B_I || FLASH_ABORT_I)
    $rose(FLASH_PROGRAM_O) |-> ##PM1 FLASH_PROGRAM_O ##1 !FLASH_PROGRAM_O)
    else $error("program strobe length wrong");
  a_busy_clear: assert property ($fell(stb) |-> ##[0:1] !FLASH_BUSY_O)
    else $error("start bit not cleared");
  a_psave_blocked: assert property (POWER_SAVE_INSTR_I && FLASH_BUSY_O |=> !LOW_POWER_ENTER_O)
    else $error("low power during operation");
  a_standby_awake: assert property (!CPU_IDLE_I |=> !REGULATOR_STANDBY_O)
    else $error("standby outside idle");
  a_wake_delay: assert property ($fell(CPU_IDLE_I) && REGULATOR_STANDBY_O |=>
    !FLASH_READY_O ##WM1 !FLASH_READY_O ##1 FLASH_READY_O) else $error("wake delay wrong");
  a_ctrl_zero: assert property (REG_RD_I && REG_ADDR_I == ADDR_CTRL |=> REG_RDATA_O[11:4] == 8'h00)
    else $error("unused control bits set");
  a_no_program_erase_enable: assert property (cwr && REG_WDATA_I[CTRL_START_BIT] && !wen_q && !FLASH_BUSY_O
    |=> !FLASH_BUSY_O ##1 !stb) else $error("start without enable ran");
  c_prog: cover property ($rose(FLASH_PROGRAM_O));
  c_erase: cover property ($rose(FLASH_ERASE_O));
  c_wake: cover property ($fell(CPU_IDLE_I) && REGULATOR_STANDBY_O);
endmodule // npec_ctrl_asserts

bind npec_ctrl npec_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) i_chk (
  .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .CPU_IDLE_I(CPU_IDLE_I),
  .POWER_SAVE_INSTR_I(POWER_SAVE_INSTR_I), .LOW_POWER_ENTER_O(LOW_POWER_ENTER_O),
  .REGULATOR_STANDBY_O(REGULATOR_STANDBY_O), .FLASH_READY_O(FLASH_READY_O),
  .FLASH_ABORT_I(FLASH_ABORT_I), .FLASH_PROGRAM_O(FLASH_PROGRAM_O),
  .FLASH_ERASE_O(FLASH_ERASE_O), .FLASH_BUSY_O(FLASH_BUSY_O));

//--- npec_ctrl_bench.sv
// npec_ctrl_bench: directed bench for the flash sequencer.
// Assumes shortened timing parameters and the flash model.
`timescale 1ns/1ps
module npec_ctrl_bench;
  import npec_pkg::*;
  localparam int P = 10;
  localparam int E = 20;
  logic        clk, rst_b, wr, rd, idle, psi, lpe, stby, rdy, abt, prog, ers, busy, irq;
  logic [1:0]  addr;
  logic [15:0] wdata, rdata, v;
  logic [7:0]  abort_at, ops;
  int          tests_run = 0;
  int          num_errors = 0;
  npec_ctrl #(.PROG_CYCLES(P), .ERASE_CYCLES(E), .WAKE_CYCLES(5)) i_dut (
    .MCLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .CPU_IDLE_I(idle), .POWER_SAVE_INSTR_I(psi),
    .LOW_POWER_ENTER_O(lpe), .REGULATOR_STANDBY_O(stby), .FLASH_READY_O(rdy),
    .FLASH_ABORT_I(abt), .FLASH_PROGRAM_O(prog), .FLASH_ERASE_O(ers), .FLASH_BUSY_O(busy),
    .IRQ_O(irq));
  npec_flash_model i_flash (.clk_i(clk), .rst_b_i(rst_b), .prog_i(prog), .erase_i(ers),
    .abort_at_i(abort_at), .abort_o(abt), .ops_o(ops));
  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // settle past the edge before looking
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse_psi;
    @(posedge clk);
    psi <= 1'b1;
    @(posedge clk);
    psi <= 1'b0;
    #1;
  endtask
  // wait bounded for a strobe, note its kind, count how long it stands
  task automatic run(output int n, output logic [1:0] kd);
    int k;
    n = 0;
    for (k = 0; k < 60 && !(prog || ers); k++) tick();
    kd = {prog, ers};
    chk({15'h0, rdy}, 16'h0001);
    while ((prog || ers) && n < 99) begin
      tick();
      n++;
    end
    if (k == 60) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic t_reset;
    tick();
    chk({9'h0, lpe, stby, rdy, prog, ers, busy, irq}, 16'h0010);
    rreg(ADDR_CTRL);
    chk(v, CTRL_RESET);
    rreg(2'h3);
    chk(v, 16'h0000);
  endtask
  // reserved codes, then a start written together with write-enable
  task automatic t_bad;
    int c;
    logic [3:0] o;
    logic [7:0] n0;
    for (c = 0; c < 17; c++) begin
      o = (c < 16) ? 4'(c) : OP_WORD_PROG;
      if (c != 1 && c != 3) begin
        n0 = ops;
        wreg(ADDR_CTRL, (c < 16) ? {12'h400, o} : 16'h0001);
        wreg(ADDR_CTRL, {12'hc00, o});
        repeat (3) tick();
        chk({13'h0, busy, prog, ers}, 16'h0000);
        chk({8'h0, ops}, {8'h0, n0});
        rreg(ADDR_CTRL);
        chk(v & 16'ha000, 16'h2000);
        rreg(ADDR_STAT);
        chk(v, 16'h0002);
      end
    end
  endtask
  task automatic t_op(input logic [3:0] op, input int n);
    int got;
    logic [1:0] kd;
    wreg(ADDR_MASK, 16'h0001);
    wreg(ADDR_CTRL, {12'h400, op});
    wreg(ADDR_CTRL, {12'hc00, op});
    run(got, kd);
    chk({14'h0, kd}, (op == OP_ERASE) ? 16'h0001 : 16'h0002);
    chk(16'(got), 16'(n));
    tick();
    chk({14'h0, busy, irq}, 16'h0001);
    rreg(ADDR_CTRL);
    chk(v, {12'h400, op});
    rreg(ADDR_STAT);
    chk(v, 16'h0001);
    tick();
    chk({15'h0, irq}, 16'h0000);
  endtask
  task automatic t_abort;
    int got;
    logic [1:0] kd;
    abort_at <= 8'h03;
    wreg(ADDR_CTRL, {12'hc00, OP_ERASE});
    run(got, kd);
    abort_at <= 8'h00;
    chk(16'(got < E), 16'h0001);
    tick();
    rreg(ADDR_CTRL);
    chk(v & 16'ha000, 16'h2000);
    rreg(ADDR_STAT);
    chk(v, 16'h0002);
  endtask
  task automatic t_psave;
    int got;
    logic [1:0] kd;
    wreg(ADDR_CTRL, {12'hc00, OP_ERASE});
    pulse_psi();
    chk({15'h0, lpe}, 16'h0000);
    run(got, kd);
    repeat (2) tick();
    rreg(ADDR_STAT);
    chk(v, 16'h0005);
    pulse_psi();
    chk({15'h0, lpe}, 16'h0001);
  endtask
  task automatic t_idle;
    int got;
    logic [1:0] kd;
    wreg(ADDR_CTRL, 16'h5ff1);
    rreg(ADDR_CTRL);
    chk(v, 16'h5001);
    @(posedge clk);
    idle <= 1'b1;
    repeat (2) tick();
    chk({15'h0, stby}, 16'h0001);
    @(posedge clk);
    idle <= 1'b0;
    wreg(ADDR_CTRL, 16'hd001);
    #1 chk({15'h0, rdy}, 16'h0000);
    run(got, kd);
    chk(16'(got), 16'(P));
    wreg(ADDR_CTRL, 16'h4001);
    @(posedge clk);
    idle <= 1'b1;
    repeat (2) tick();
    chk({14'h0, stby, rdy}, 16'h0001);
    @(posedge clk);
    idle <= 1'b0;
    repeat (3) tick();
    chk({15'h0, rdy}, 16'h0001);
  endtask
  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    {rst_b, wr, rd, idle, psi, addr, wdata, abort_at} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_bad();
    t_op(OP_WORD_PROG, P);
    t_op(OP_ERASE, E);
    t_abort();
    t_psave();
    t_idle();
    print_verdict();
  end
endmodule // npec_ctrl_bench

//--- npec_flash_model.sv
// npec_flash_model: behavioural flash array behind the sequencer.
// Assumes registered strobes on the system clock.
`timescale 1ns/1ps
module npec_flash_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // strobes and bench command
  input  wire logic       prog_i,
  input  wire logic       erase_i,
  input  wire logic [7:0] abort_at_i, // strobe age to cut short, 0 never
  output logic            abort_o,
  output logic [7:0]      ops_o
);
  logic [7:0] age_q;
  logic       run;
  assign run = prog_i || erase_i;
  // strobe age; abort only when the bench asks, never on its own
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      age_q   <= 8'h00;
      abort_o <= 1'b0;
    end else begin
      age_q   <= run ? age_q + 8'h01 : 8'h00;
      abort_o <= run && (abort_at_i != 8'h00) && (age_q + 8'h01 == abort_at_i);
    end
  end
  // cycles started on the array; refused requests must not add
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ops_o <= 8'h00;
    end else if (run && age_q == 8'h00) begin
      ops_o <= ops_o + 8'h01;
    end
  end
endmodule // npec_flash_model

//--- npec_pkg.sv
// npec_pkg: shared constants and types for the flash program/erase sequencer.
// Assumes a 40 MHz system clock; all cycle counts are derived from it here.
package npec_pkg;

  // register port map, word index on the plain register port
  localparam int         REG_AW         = 2;
  localparam logic [1:0] ADDR_CTRL      = 2'h0;
  localparam logic [1:0] ADDR_STAT      = 2'h1;
  localparam logic [1:0] ADDR_MASK      = 2'h2;

  // flash_operation_control field positions
  localparam int         CTRL_W         = 16;
  localparam int         CTRL_START_BIT = 15;
  localparam int         CTRL_PROGRAM_ERASE_ENABLE_BIT  = 14;
  localparam int         CTRL_ERR_BIT   = 13;
  localparam int         CTRL_SIDL_BIT  = 12;
  localparam int         OP_MSB         = 3;
  localparam int         OP_LSB         = 0;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;

  // operation_select codes; word program and erase start a real operation, the reset code does not
  localparam logic [3:0] OP_WORD_PROG   = 4'h1;
  localparam logic [3:0] OP_ERASE       = 4'h3;
  localparam logic [3:0] OP_RESET       = 4'h0;

  // event status and mask layout
  localparam int         STAT_W         = 3;
  localparam int         STAT_DONE_BIT  = 0;
  localparam int         STAT_ERR_BIT   = 1;
  localparam int         STAT_PSI_BIT   = 2;
  localparam logic [2:0] STAT_RESET     = 3'h0;
  localparam logic [2:0] MASK_RESET     = 3'h0;

  // timing, figures in their own units
  localparam int         CLK_FREQ_MHZ   = 40;
  localparam int         PROG_TIME_NS   = 20000;
  localparam int         ERASE_TIME_US  = 20000;
  localparam int         WAKE_TIME_NS   = 10000;
  localparam int         PROG_CYC       = (PROG_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int         ERASE_CYC      = ERASE_TIME_US * CLK_FREQ_MHZ;
  localparam int         WAKE_CYC       = (WAKE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int         TMR_W          = 20;
  localparam int         WAKE_W         = 9;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    NPEC_IDLE   = 4'b0001,
    NPEC_PEND   = 4'b0010,
    NPEC_RUN    = 4'b0100,
    NPEC_FINISH = 4'b1000
  } npec_state_t;

endpackage : npec_pkg

//--- npec_timer.sv
// npec_timer: down counter that times one program or erase cycle.
// Assumes count is at least one when load pulses; stop wins over load.
`timescale 1ns/1ps
module npec_timer
  import npec_pkg::*;
#(
  parameter int W = TMR_W
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // sequencer side
  npec_tmr_if.tmr   tif
);

  logic [W-1:0] cnt_q;
  logic         busy_q;

  // count down; the strobe must stand exactly the load value, so expiry
  // is flagged during the last counted cycle, not one cycle after it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (tif.stop) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (tif.load) begin
      cnt_q  <= tif.count;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - W'(1);
      busy_q <= (cnt_q != W'(1));
    end
  end

  assign tif.busy   = busy_q;
  assign tif.expire = busy_q && (cnt_q == W'(1));

endmodule : npec_timer

//--- npec_tmr_if.sv
// npec_tmr_if: carrier between the sequencer and its operation timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface npec_tmr_if #(parameter int W = 20);
  logic         load;    // one-cycle pulse, take count and start
  logic         stop;    // one-cycle pulse, abandon the timed cycle
  logic [W-1:0] count;   // cycles to run, at least one
  logic         busy;    // level, timer running
  logic         expire;  // one-cycle pulse, last cycle of the count

  modport ctrl (output load, output stop, output count, input busy, input expire);
  modport tmr  (input load, input stop, input count, output busy, output expire);
endinterface : npec_tmr_if
